// file: common/dcc_pkg.sv
// Constants and types of the disk command decoder.
// Assumes a single controller clock; imported by the decoder, the monitor, the engine model and the bench.
package dcc_pkg;

  // ---------------------------------------------------------------
  // Command encoding
  // ---------------------------------------------------------------
  localparam logic [2:0] CLASS_DISK = 3'h0;
  localparam logic [2:0] CLASS_DIAG = 3'h7;
  localparam logic [4:0] OPC_CHECK_TRACK = 5'h05;
  localparam logic [4:0] OPC_FORMAT_TRACK = 5'h06;
  localparam logic [4:0] OPC_FORMAT_BAD = 5'h07;
  localparam logic [4:0] OPC_READ = 5'h08;
  localparam logic [4:0] OPC_WRITE = 5'h0A;
  localparam logic [4:0] OPC_SEEK = 5'h0B;
  localparam logic [4:0] OPC_DRIVE_SETUP = 5'h0C;
  localparam logic [4:0] OPC_BURST_QUERY = 5'h0D;
  localparam logic [4:0] OPC_RAM_TEST = 5'h00;
  localparam logic [4:0] OPC_DRIVE_TEST = 5'h03;
  localparam logic [4:0] OPC_SELF_TEST = 5'h04;
  localparam logic [4:0] OPC_READ_LONG = 5'h05;
  localparam logic [4:0] OPC_WRITE_LONG = 5'h06;

  localparam int CMD_BYTES = 6;
  localparam int PARAM_BYTES = 8;
  localparam logic [7:0] FORMAT_FILL = 8'h6C;

  // ---------------------------------------------------------------
  // Defaults after reset and result codes
  // ---------------------------------------------------------------
  localparam logic [15:0] DEF_MAX_CYL = 16'd153;
  localparam logic [3:0] DEF_MAX_HEAD = 4'd4;
  localparam logic [15:0] DEF_RWC_CYL = 16'd128;
  localparam logic [15:0] DEF_PCOMP_CYL = 16'd64;
  localparam logic [3:0] DEF_MAX_BURST = 4'd11;

  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_DATA_UNCORR = 8'h11;
  localparam logic [7:0] ERR_DATA_CORR = 8'h18;
  localparam logic [7:0] ERR_INVALID_CMD = 8'h20;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_CHECK_TRACK = 4'h1, OP_FORMAT_TRACK = 4'h2, OP_FORMAT_BAD = 4'h3,
    OP_READ = 4'h4, OP_WRITE = 4'h5, OP_SEEK = 4'h6, OP_RAM_TEST = 4'h7,
    OP_DRIVE_TEST = 4'h8, OP_SELF_TEST = 4'h9, OP_READ_LONG = 4'hA, OP_WRITE_LONG = 4'hB
  } dcc_op_t;

  typedef enum logic [1:0] {
    ST_CMD = 2'b00, ST_PARAM = 2'b01, ST_EXEC = 2'b11, ST_REPLY = 2'b10
  } dcc_state_t;

endpackage : dcc_pkg

// file: verilog/dcc_decoder.sv
// Command descriptor block decoder and sequencer of a fixed-disk controller.
// Assumes a byte-wide host stream and a drive engine that runs each operation
// it is handed and answers with a done pulse and a result code.
`timescale 1ns/1ps
`default_nettype none
module dcc_decoder #(
  parameter int ECC_BITS = 32
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SECTOR_512_I,
  input wire logic HOST_VALID_I,
  input wire logic [7:0] HOST_DATA_I,
  output logic HOST_READY_O,
  output logic TX_VALID_O,
  output logic [7:0] TX_DATA_O,
  input wire logic TX_READY_I,
  output logic OP_START_O,
  output dcc_pkg::dcc_op_t OP_KIND_O,
  output logic OP_DRIVE_O,
  output logic [20:0] OP_ADDR_O,
  output logic [7:0] OP_COUNT_O,
  output logic [4:0] OP_INTERLEAVE_O,
  output logic OP_RETRY_DIS_O,
  output logic OP_DATA_RETRY_O,
  output logic [2:0] OP_STEP_O,
  output logic OP_SECTOR_512_O,
  output logic OP_READ_DATA_O,
  output logic OP_WRITE_DATA_O,
  output logic [7:0] OP_FILL_O,
  output logic OP_BAD_FLAG_O,
  output logic OP_HOST_ECC_O,
  output logic OP_DRIVE_ACCESS_O,
  input wire logic ENG_DONE_I,
  input wire logic [7:0] ENG_ERR_I,
  input wire logic ECC_EVT_I,
  input wire logic [ECC_BITS-1:0] ECC_MASK_I,
  output logic ECC_CORRECT_O,
  output logic DONE_O,
  output logic [7:0] ERR_CODE_O,
  output logic [15:0] MAX_CYL_O,
  output logic [3:0] MAX_HEAD_O,
  output logic [15:0] RWC_CYL_O,
  output logic [15:0] PCOMP_CYL_O,
  output logic [3:0] MAX_BURST_O
);
  import dcc_pkg::*;

  // The burst length is counted in eight bits, so a wider mask cannot be served
  if (ECC_BITS < 8 || ECC_BITS > 255) begin : g_ecc_bits_check
    $error("ECC_BITS must lie between 8 and 255");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    dcc_state_t st;
    logic [3:0] cnt;
    logic [5:0][7:0] cdb;
    logic [15:0] max_cyl;
    logic [3:0] max_head;
    logic [15:0] rwc;
    logic [15:0] pcomp;
    logic [3:0] max_burst;
    logic [7:0] burst;
    logic [7:0] err;
    dcc_op_t op;
    logic start;
    logic done;
    logic ready;
    logic tx_valid;
    logic correct;
    logic sec512;
    logic rd_data;
    logic wr_data;
    logic bad_flag;
    logic host_ecc;
    logic no_corr;
    logic drv_access;
    logic [7:0] fill;
    logic [7:0] result;
  } dcc_regs_t;

  dcc_regs_t r_q, r_d;

  // ---------------------------------------------------------------
  // Burst length of an error mask
  // ---------------------------------------------------------------
  function automatic logic [7:0] burst_len(input logic [ECC_BITS-1:0] m);
    logic [7:0] lo;
    logic [7:0] hi;
    logic seen;
    lo = 8'h00;
    hi = 8'h00;
    seen = 1'b0;
    for (int i = 0; i < ECC_BITS; i++) begin
      if (m[i]) begin
        if (!seen) begin
          lo = 8'(i);
        end
        hi = 8'(i);
        seen = 1'b1;
      end
    end
    burst_len = seen ? 8'(hi - lo + 8'h01) : 8'h00;
  endfunction : burst_len

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic [7:0] b0;
  logic [2:0] cls;
  logic [4:0] opc;
  logic [7:0] blen;
  dcc_op_t kind;
  logic invalid;

  always_comb begin
    r_d = r_q;
    r_d.start = 1'b0;
    r_d.done = 1'b0;
    r_d.correct = 1'b0;
    b0 = r_q.cdb[0];
    cls = b0[7:5];
    opc = b0[4:0];
    blen = burst_len(ECC_MASK_I);
    kind = OP_NONE;
    invalid = 1'b0;
    if (cls == CLASS_DISK) begin
      case (opc)
        OPC_CHECK_TRACK: kind = OP_CHECK_TRACK;
        OPC_FORMAT_TRACK: kind = OP_FORMAT_TRACK;
        OPC_FORMAT_BAD: kind = OP_FORMAT_BAD;
        OPC_READ: kind = OP_READ;
        OPC_WRITE: kind = OP_WRITE;
        OPC_SEEK: kind = OP_SEEK;
        OPC_DRIVE_SETUP, OPC_BURST_QUERY: kind = OP_NONE;
        default: invalid = 1'b1;
      endcase
    end else if (cls == CLASS_DIAG) begin
      case (opc)
        OPC_RAM_TEST: kind = OP_RAM_TEST;
        OPC_DRIVE_TEST: kind = OP_DRIVE_TEST;
        OPC_SELF_TEST: kind = OP_SELF_TEST;
        OPC_READ_LONG: kind = OP_READ_LONG;
        OPC_WRITE_LONG: kind = OP_WRITE_LONG;
        default: invalid = 1'b1;
      endcase
    end else begin
      invalid = 1'b1;
    end
    case (r_q.st)
      ST_CMD: begin
        if (HOST_VALID_I && r_q.ready) begin
          r_d.cdb[r_q.cnt[2:0]] = HOST_DATA_I;
          r_d.cnt = r_q.cnt + 4'h1;
          if (r_q.cnt == 4'(CMD_BYTES - 1)) begin
            r_d.cnt = 4'h0;
            r_d.st = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        if (!r_q.start && r_q.op == OP_NONE && !r_q.done) begin
          // First cycle after the block arrived: decode it.
          r_d.err = ERR_NONE;
          r_d.sec512 = SECTOR_512_I;
          if (invalid) begin
            r_d.result = ERR_INVALID_CMD;
            r_d.done = 1'b1;
            r_d.st = ST_CMD;
          end else if (cls == CLASS_DISK && opc == OPC_DRIVE_SETUP) begin
            r_d.st = ST_PARAM;
          end else if (cls == CLASS_DISK && opc == OPC_BURST_QUERY) begin
            r_d.tx_valid = 1'b1;
            r_d.st = ST_REPLY;
          end else begin
            r_d.op = kind;
            r_d.start = 1'b1;
            r_d.rd_data = kind inside {OP_READ, OP_READ_LONG, OP_DRIVE_TEST};
            r_d.wr_data = kind inside {OP_FORMAT_TRACK, OP_WRITE, OP_WRITE_LONG};
            r_d.bad_flag = (kind == OP_FORMAT_BAD);
            r_d.fill = (kind == OP_FORMAT_TRACK) ? FORMAT_FILL : 8'h00;
            r_d.host_ecc = (kind == OP_WRITE_LONG);
            r_d.no_corr = (kind == OP_READ_LONG);
            r_d.drv_access = !(kind inside {OP_RAM_TEST, OP_SELF_TEST});
          end
        end else if (r_q.op != OP_NONE) begin
          if (ECC_EVT_I && r_q.rd_data && !r_q.no_corr) begin
            r_d.burst = blen;
            if (blen > {4'h0, r_q.max_burst}) begin
              r_d.err = ERR_DATA_UNCORR;
            end else if (blen != 8'h00) begin
              r_d.correct = 1'b1;
              if (r_q.err != ERR_DATA_UNCORR) begin
                r_d.err = ERR_DATA_CORR;
              end
            end
          end
          // The engine never answers in the start cycle, so no guard is needed here.
          if (ENG_DONE_I) begin
            // Drive faults outrank the data-field verdict.
            r_d.result = (ENG_ERR_I != ERR_NONE) ? ENG_ERR_I : r_q.err;
            r_d.done = 1'b1;
            r_d.op = OP_NONE;
            r_d.st = ST_CMD;
          end
        end
      end
      ST_PARAM: begin
        if (HOST_VALID_I && r_q.ready) begin
          case (r_q.cnt)
            4'h0: r_d.max_cyl[15:8] = HOST_DATA_I;
            4'h1: r_d.max_cyl[7:0] = HOST_DATA_I;
            4'h2: r_d.max_head = HOST_DATA_I[3:0];
            4'h3: r_d.rwc[15:8] = HOST_DATA_I;
            4'h4: r_d.rwc[7:0] = HOST_DATA_I;
            4'h5: r_d.pcomp[15:8] = HOST_DATA_I;
            4'h6: r_d.pcomp[7:0] = HOST_DATA_I;
            default: r_d.max_burst = HOST_DATA_I[3:0];
          endcase
          r_d.cnt = r_q.cnt + 4'h1;
          if (r_q.cnt == 4'(PARAM_BYTES - 1)) begin
            r_d.cnt = 4'h0;
            r_d.result = ERR_NONE;
            r_d.done = 1'b1;
            r_d.st = ST_CMD;
          end
        end
      end
      ST_REPLY: begin
        // Reply byte stands until the host takes it; no time limit is kept.
        if (TX_READY_I) begin
          r_d.tx_valid = 1'b0;
          r_d.result = ERR_NONE;
          r_d.done = 1'b1;
          r_d.st = ST_CMD;
        end
      end
      default: begin
        r_d.st = ST_CMD;
        r_d.cnt = 4'h0;
      end
    endcase
    // Ready is registered, so it follows the state one cycle ahead.
    r_d.ready = (r_d.st == ST_CMD || r_d.st == ST_PARAM) && !(r_q.ready && HOST_VALID_I &&
                ((r_q.st == ST_CMD && r_q.cnt == 4'(CMD_BYTES - 1)) ||
                 (r_q.st == ST_PARAM && r_q.cnt == 4'(PARAM_BYTES - 1))));
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      r_q <= '0;
      r_q.st <= ST_CMD;
      r_q.op <= OP_NONE;
      r_q.max_cyl <= DEF_MAX_CYL;
      r_q.max_head <= DEF_MAX_HEAD;
      r_q.rwc <= DEF_RWC_CYL;
      r_q.pcomp <= DEF_PCOMP_CYL;
      r_q.max_burst <= DEF_MAX_BURST;
    end else begin
      r_q <= r_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign HOST_READY_O = r_q.ready;
  assign TX_VALID_O = r_q.tx_valid;
  assign TX_DATA_O = r_q.burst;
  assign OP_START_O = r_q.start;
  assign OP_KIND_O = r_q.op;
  assign OP_DRIVE_O = r_q.cdb[1][5];
  assign OP_ADDR_O = {r_q.cdb[1][4:0], r_q.cdb[2], r_q.cdb[3]};
  assign OP_COUNT_O = r_q.cdb[4];
  assign OP_INTERLEAVE_O = r_q.cdb[4][4:0];
  assign OP_RETRY_DIS_O = r_q.cdb[5][7];
  assign OP_DATA_RETRY_O = r_q.cdb[5][6];
  assign OP_STEP_O = r_q.cdb[5][2:0];
  assign OP_SECTOR_512_O = r_q.sec512;
  assign OP_READ_DATA_O = r_q.rd_data;
  assign OP_WRITE_DATA_O = r_q.wr_data;
  assign OP_FILL_O = r_q.fill;
  assign OP_BAD_FLAG_O = r_q.bad_flag;
  assign OP_HOST_ECC_O = r_q.host_ecc;
  assign OP_DRIVE_ACCESS_O = r_q.drv_access;
  assign ECC_CORRECT_O = r_q.correct;
  assign DONE_O = r_q.done;
  assign ERR_CODE_O = r_q.result;
  assign MAX_CYL_O = r_q.max_cyl;
  assign MAX_HEAD_O = r_q.max_head;
  assign RWC_CYL_O = r_q.rwc;
  assign PCOMP_CYL_O = r_q.pcomp;
  assign MAX_BURST_O = r_q.max_burst;

endmodule : dcc_decoder
`default_nettype wire

// file: bench/dcc_monitor.sv
// Concurrent checks on the decoder's top-level ports.
// Assumes one clock domain; bound into every decoder instance.
`timescale 1ns/1ps
`default_nettype none
module dcc_monitor import dcc_pkg::*; (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic OP_START_O,
  input wire dcc_op_t OP_KIND_O,
  input wire logic OP_READ_DATA_O,
  input wire logic OP_WRITE_DATA_O,
  input wire logic [7:0] OP_FILL_O,
  input wire logic OP_BAD_FLAG_O,
  input wire logic OP_HOST_ECC_O,
  input wire logic OP_DRIVE_ACCESS_O,
  input wire logic ECC_CORRECT_O,
  input wire logic TX_VALID_O,
  input wire logic TX_READY_I,
  input wire logic DONE_O,
  input wire logic [7:0] ERR_CODE_O,
  input wire logic [15:0] MAX_CYL_O,
  input wire logic [3:0] MAX_HEAD_O,
  input wire logic [15:0] RWC_CYL_O,
  input wire logic [15:0] PCOMP_CYL_O,
  input wire logic [3:0] MAX_BURST_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  sequence started(dcc_op_t k);
    OP_START_O && OP_KIND_O == k;
  endsequence
  sequence reply_taken;
    TX_VALID_O && TX_READY_I;
  endsequence
  reset_defaults_a: assert property ($fell(RST_I) |-> MAX_CYL_O == 16'h0099 && MAX_HEAD_O == 4'h4
    && RWC_CYL_O == 16'h0080 && PCOMP_CYL_O == 16'h0040 && MAX_BURST_O == 4'hB) else $error("bad reset parameters");
  check_nodata_a: assert property (started(OP_CHECK_TRACK) |-> !OP_READ_DATA_O && !OP_WRITE_DATA_O)
    else $error("check track touches data");
  fill_pattern_a: assert property (started(OP_FORMAT_TRACK) |-> OP_FILL_O == 8'h6C && !OP_BAD_FLAG_O
    && OP_WRITE_DATA_O) else $error("format track setup wrong");
  bad_flag_a: assert property (started(OP_FORMAT_BAD) |-> OP_BAD_FLAG_O && !OP_WRITE_DATA_O)
    else $error("bad track setup wrong");
  read_dir_a: assert property (started(OP_READ) |-> OP_READ_DATA_O && !OP_WRITE_DATA_O)
    else $error("read direction wrong");
  write_dir_a: assert property (started(OP_WRITE) |-> OP_WRITE_DATA_O && !OP_READ_DATA_O)
    else $error("write direction wrong");
  drive_test_a: assert property (started(OP_DRIVE_TEST) |-> OP_DRIVE_ACCESS_O && !OP_WRITE_DATA_O)
    else $error("drive test writes");
  no_drive_a: assert property (started(OP_SELF_TEST) or started(OP_RAM_TEST) |-> !OP_DRIVE_ACCESS_O)
    else $error("internal test touches drive");
  long_nocorrect_a: assert property (OP_KIND_O == OP_READ_LONG |-> !ECC_CORRECT_O)
    else $error("read long corrected");
  host_ecc_a: assert property (started(OP_WRITE_LONG) |-> OP_HOST_ECC_O && OP_WRITE_DATA_O)
    else $error("write long ecc source wrong");
  reply_done_a: assert property (reply_taken |=> !TX_VALID_O && DONE_O && ERR_CODE_O == 8'h00)
    else $error("reply not closed");
endmodule : dcc_monitor
bind dcc_decoder dcc_monitor mon (.CLK_I, .RST_I, .OP_START_O, .OP_KIND_O, .OP_READ_DATA_O, .OP_WRITE_DATA_O,
  .OP_FILL_O, .OP_BAD_FLAG_O, .OP_HOST_ECC_O, .OP_DRIVE_ACCESS_O, .ECC_CORRECT_O, .TX_VALID_O, .TX_READY_I,
  .DONE_O, .ERR_CODE_O, .MAX_CYL_O, .MAX_HEAD_O, .RWC_CYL_O, .PCOMP_CYL_O, .MAX_BURST_O);
`default_nettype wire

// file: bench/dcc_eng_model.sv
// Behavioural drive engine: answers each started operation after a delay.
// Assumes start is a one-cycle pulse; released lines show inverted values.
`timescale 1ns/1ps
`default_nettype none
module dcc_eng_model import dcc_pkg::*; (
  input wire logic clk_i,
  input wire logic start_i,
  input wire dcc_op_t kind_i,
  input wire logic [31:0] mask_i,
  input wire logic [7:0] err_i,
  output logic done_o,
  output logic evt_o,
  output logic [31:0] mask_o,
  output logic [7:0] err_o
);
  initial begin
    done_o = 1'b0;
    evt_o = 1'b0;
    mask_o = 32'h0;
    err_o = 8'h0;
    forever begin
      @(posedge clk_i);
      #1;
      if (start_i === 1'b1) begin
        repeat (3) @(posedge clk_i);
        #1;
        // Only data-reading operations see a data-field check
        if (mask_i != 32'h0 && kind_i inside {OP_READ, OP_READ_LONG, OP_DRIVE_TEST}) begin
          evt_o = 1'b1;
          mask_o = mask_i;
          @(posedge clk_i);
          #1;
          evt_o = 1'b0;
          mask_o = ~mask_i;
        end
        done_o = 1'b1;
        err_o = err_i;
        @(posedge clk_i);
        #1;
        done_o = 1'b0;
        err_o = ~err_i;
      end
    end
  end
endmodule : dcc_eng_model
`default_nettype wire

// file: bench/dcc_tb.sv
// Self-checking bench: host byte stream from tasks, engine from the model.
// Assumes dcc_pkg, the decoder, monitor and engine model compiled before.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %0h got %0h", nm, e, a); end end
module testbench;
  import dcc_pkg::*;
  logic CLK_I, RST_I, SECTOR_512_I, HOST_VALID_I, TX_READY_I, HOST_READY_O, TX_VALID_O, OP_START_O, OP_DRIVE_O;
  logic OP_RETRY_DIS_O, OP_DATA_RETRY_O, OP_SECTOR_512_O, OP_READ_DATA_O, OP_WRITE_DATA_O, OP_BAD_FLAG_O;
  logic OP_HOST_ECC_O, OP_DRIVE_ACCESS_O, ENG_DONE_I, ECC_EVT_I, ECC_CORRECT_O, DONE_O, st, cor;
  logic [7:0] HOST_DATA_I, TX_DATA_O, ENG_ERR_I, ERR_CODE_O, OP_COUNT_O, OP_FILL_O, eerr, r, code;
  logic [7:0] bb [6];
  logic [7:0] pb [8];
  logic [20:0] OP_ADDR_O;
  logic [4:0] OP_INTERLEAVE_O;
  logic [2:0] OP_STEP_O;
  logic [31:0] ECC_MASK_I, msk;
  logic [15:0] MAX_CYL_O, RWC_CYL_O, PCOMP_CYL_O;
  logic [3:0] MAX_HEAD_O, MAX_BURST_O;
  dcc_op_t OP_KIND_O, kd;
  logic [55:0] prm;
  assign prm = {MAX_CYL_O, MAX_HEAD_O, RWC_CYL_O, PCOMP_CYL_O, MAX_BURST_O};
  int n_fail = 0, cmp_count = 0, lim = 11, n;
  localparam logic [7:0] B0 [15] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'hE0, 8'hE3, 8'hE4, 8'hE5,
    8'hE6, 8'h09, 8'hE1, 8'hE2, 8'h65};
  localparam dcc_op_t KD [15] = '{OP_CHECK_TRACK, OP_FORMAT_TRACK, OP_FORMAT_BAD, OP_READ, OP_WRITE, OP_SEEK,
    OP_RAM_TEST, OP_DRIVE_TEST, OP_SELF_TEST, OP_READ_LONG, OP_WRITE_LONG, OP_NONE, OP_NONE, OP_NONE, OP_NONE};
  dcc_decoder dut (.CLK_I, .RST_I, .SECTOR_512_I, .HOST_VALID_I, .HOST_DATA_I, .HOST_READY_O, .TX_VALID_O,
    .TX_DATA_O, .TX_READY_I, .OP_START_O, .OP_KIND_O, .OP_DRIVE_O, .OP_ADDR_O, .OP_COUNT_O, .OP_INTERLEAVE_O,
    .OP_RETRY_DIS_O, .OP_DATA_RETRY_O, .OP_STEP_O, .OP_SECTOR_512_O, .OP_READ_DATA_O, .OP_WRITE_DATA_O,
    .OP_FILL_O, .OP_BAD_FLAG_O, .OP_HOST_ECC_O, .OP_DRIVE_ACCESS_O, .ENG_DONE_I, .ENG_ERR_I, .ECC_EVT_I,
    .ECC_MASK_I, .ECC_CORRECT_O, .DONE_O, .ERR_CODE_O, .MAX_CYL_O, .MAX_HEAD_O, .RWC_CYL_O, .PCOMP_CYL_O,
    .MAX_BURST_O);
  dcc_eng_model eng (.clk_i(CLK_I), .start_i(OP_START_O), .kind_i(OP_KIND_O), .mask_i(msk), .err_i(eerr),
    .done_o(ENG_DONE_I), .evt_o(ECC_EVT_I), .mask_o(ECC_MASK_I), .err_o(ENG_ERR_I));
  initial begin
    CLK_I = 1'b0;
    forever #4 CLK_I = ~CLK_I;
  end
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nxt
  function automatic int blen(input logic [31:0] m);
    int f, l;
    f = -1;
    l = 0;
    for (int k = 0; k < 32; k++) if (m[k]) begin
      if (f < 0) f = k;
      l = k;
    end
    return (f < 0) ? 0 : l - f + 1;
  endfunction : blen
  task automatic finish_test(input logic to);
    if (to) n_fail++;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic tick();
    @(posedge CLK_I);
    #1;
  endtask : tick
  // Byte is held until an edge that sees ready high
  task automatic send(input logic [7:0] b);
    HOST_VALID_I = 1'b1;
    HOST_DATA_I = b;
    for (n = 0; HOST_READY_O !== 1'b1; n++) begin
      tick();
      if (n > 50) finish_test(1'b1);
    end
    tick();
  endtask : send
  task automatic idle();
    HOST_VALID_I = 1'b0;
    HOST_DATA_I = ~HOST_DATA_I;
    tick();
  endtask : idle
  // Parameters must fall back to their defaults at every release
  task automatic do_reset();
    RST_I = 1'b1;
    repeat (3) tick();
    RST_I = 1'b0;
    lim = 11;
    `CHK("defaults", {16'd153, 4'd4, 16'd128, 16'd64, 4'd11}, prm)
    $display("test reset done");
  endtask : do_reset
  task automatic send6(input logic [7:0] b0);
    bb[0] = b0;
    for (int k = 1; k < 6; k++) begin
      r = nxt(r);
      bb[k] = r;
    end
    bb[1] &= 8'h3F;
    bb[4] = {4'h0, bb[4][3:0]} + 8'h01;
    bb[5] &= 8'hC7;
    SECTOR_512_I = r[1];
    for (int k = 0; k < 6; k++) send(bb[k]);
    idle();
  endtask : send6
  task automatic wait_done();
    st = 1'b0;
    cor = 1'b0;
    kd = OP_NONE;
    // Start stands in the cycle in which this task is entered, so sample before the first tick
    for (n = 0; DONE_O !== 1'b1; n++) begin
      st = st | (OP_START_O === 1'b1);
      cor = cor | (ECC_CORRECT_O === 1'b1);
      if (OP_START_O === 1'b1) kd = OP_KIND_O;
      tick();
      if (n > 100) finish_test(1'b1);
    end
    code = ERR_CODE_O;
    tick();
  endtask : wait_done
  task automatic cmd(input int i, input logic [31:0] m);
    logic [7:0] ee;
    msk = m;
    eerr = (KD[i] == OP_SEEK) ? 8'h15 : 8'h00;
    ee = (KD[i] == OP_NONE) ? 8'h20 : (eerr != 8'h00) ? eerr : (m != 0 && KD[i] inside {OP_READ, OP_DRIVE_TEST})
      ? ((blen(m) > lim) ? 8'h11 : 8'h18) : 8'h00;
    send6(B0[i]);
    wait_done();
    `CHK("start", KD[i] != OP_NONE, st)
    `CHK("code", ee, code)
    `CHK("corrected", ee == 8'h18, cor)
    if (KD[i] != OP_NONE) begin
      `CHK("kind", KD[i], kd)
      `CHK("interleave", bb[4][4:0], OP_INTERLEAVE_O)
      `CHK("drive", bb[1][5], OP_DRIVE_O)
      `CHK("addr", {bb[1][4:0], bb[2], bb[3]}, OP_ADDR_O)
      `CHK("count", bb[4], OP_COUNT_O)
      `CHK("options", {bb[5][7:6], bb[5][2:0]}, {OP_RETRY_DIS_O, OP_DATA_RETRY_O, OP_STEP_O})
      `CHK("size", SECTOR_512_I, OP_SECTOR_512_O)
    end
    $display("test command %0h mask %0h done", B0[i], m);
  endtask : cmd
  initial begin
    {SECTOR_512_I, HOST_VALID_I, TX_READY_I} = 3'h0;
    HOST_DATA_I = 8'h00;
    msk = 32'h0;
    eerr = 8'h00;
    r = 8'h49;
    do_reset();
    for (int i = 0; i < 15; i++) cmd(i, 32'h0);
    cmd(3, 32'h401);
    cmd(3, 32'h801);
    send6(8'h0C);
    for (int k = 0; k < 8; k++) begin
      r = nxt(r);
      pb[k] = (k == 7) ? 8'h04 : r;
      send(pb[k]);
    end
    // Done stands only in the cycle after the last byte, so look before going idle
    wait_done();
    idle();
    `CHK("setup code", 8'h00, code)
    `CHK("params", {pb[0], pb[1], pb[2][3:0], pb[3], pb[4], pb[5], pb[6], 4'h4}, prm)
    $display("test drive setup done");
    lim = 4;
    cmd(3, 32'hC5);
    cmd(7, 32'h0D);
    send6(8'h0D);
    for (n = 0; TX_VALID_O !== 1'b1; n++) begin
      tick();
      if (n > 50) finish_test(1'b1);
    end
    `CHK("burst byte", 8'h04, TX_DATA_O)
    TX_READY_I = 1'b1;
    tick();
    TX_READY_I = 1'b0;
    wait_done();
    `CHK("query code", 8'h00, code)
    $display("test burst query done");
    do_reset();
    cmd(9, 32'hC5);
    finish_test(1'b0);
  end
endmodule : testbench
`default_nettype wire
